// >>> rtl/aba_pkg.sv
// Register page zero: line-input routing, bias and left gain control.
// Assumes a byte-wide register port driven from logic on the same clock.
package aba_pkg;

  // Register offsets on page zero
  localparam logic [6:0] ROUTE_ADDR = 7'h18;
  localparam logic [6:0] BIAS_ADDR = 7'h19;
  localparam logic [6:0] AGC_ADDR = 7'h1a;

  // Reset values
  localparam logic [7:0] ROUTE_RESET = 8'h78;
  localparam logic [7:0] BIAS_RESET = 8'h00;
  localparam logic [7:0] AGC_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Writable bit masks; reserved bits stay zero
  localparam logic [7:0] ROUTE_WR_MASK = 8'hf8;
  localparam logic [7:0] BIAS_WR_MASK = 8'hf0;
  localparam logic [7:0] AGC_WR_MASK = 8'hff;

  // Field positions
  localparam int ROUTE_DIFF_BIT = 7;
  localparam int ROUTE_LVL_HI = 6;
  localparam int ROUTE_LVL_LO = 3;
  localparam int BIAS_LVL_HI = 7;
  localparam int BIAS_LVL_LO = 6;
  localparam int BIAS_DMIC_HI = 5;
  localparam int BIAS_DMIC_LO = 4;
  localparam int AGC_EN_BIT = 7;
  localparam int AGC_TGT_HI = 6;
  localparam int AGC_TGT_LO = 4;
  localparam int AGC_ATK_HI = 3;
  localparam int AGC_ATK_LO = 2;
  localparam int AGC_DCY_HI = 1;
  localparam int AGC_DCY_LO = 0;

  // Input level codes
  localparam logic [3:0] LVL_MAX_CODE = 4'h8;
  localparam logic [3:0] LVL_OPEN_CODE = 4'hf;

  // Bias level codes
  localparam logic [1:0] BIAS_OFF = 2'h0;
  localparam logic [1:0] BIAS_2V0 = 2'h1;
  localparam logic [1:0] BIAS_2V5 = 2'h2;
  localparam logic [1:0] BIAS_SUPPLY = 2'h3;

  // Digital microphone assignment codes
  localparam logic [1:0] DMIC_BOTH = 2'h0;
  localparam logic [1:0] DMIC_LEFT = 2'h1;
  localparam logic [1:0] DMIC_RIGHT = 2'h2;
  localparam logic [1:0] DMIC_RSVD = 2'h3;

  // Target levels in half-dB below full scale
  localparam logic [5:0] TGT_HALF_DB_0 = 6'h0b;
  localparam logic [5:0] TGT_HALF_DB_1 = 6'h10;
  localparam logic [5:0] TGT_HALF_DB_2 = 6'h14;
  localparam logic [5:0] TGT_HALF_DB_3 = 6'h18;
  localparam logic [5:0] TGT_HALF_DB_4 = 6'h1c;
  localparam logic [5:0] TGT_HALF_DB_5 = 6'h22;
  localparam logic [5:0] TGT_HALF_DB_6 = 6'h28;
  localparam logic [5:0] TGT_HALF_DB_7 = 6'h30;

  // Attack times in milliseconds
  localparam logic [4:0] ATK_MS_0 = 5'h08;
  localparam logic [4:0] ATK_MS_1 = 5'h0b;
  localparam logic [4:0] ATK_MS_2 = 5'h10;
  localparam logic [4:0] ATK_MS_3 = 5'h14;

  // Decay times in milliseconds
  localparam logic [8:0] DCY_MS_0 = 9'h064;
  localparam logic [8:0] DCY_MS_1 = 9'h0c8;
  localparam logic [8:0] DCY_MS_2 = 9'h190;
  localparam logic [8:0] DCY_MS_3 = 9'h1f4;

endpackage

// >>> rtl/aba_level_dec.sv
// Input level decoder: gain code to connection and attenuation.
// Assumes the code comes straight from the routing register.
`timescale 1ns/1ps
module aba_level_dec
  import aba_pkg::*;
(
  input wire logic [3:0] levelCode,
  output logic connected,
  output logic [4:0] attenHalfDb
);

  // Gain codes 0..8 connect; reserved and open codes leave it off
  always_comb begin
    connected = (levelCode <= LVL_MAX_CODE);
    // Three half-dB per code step, zero when not connected
    if (connected) begin
      attenHalfDb = 5'({1'b0, levelCode} + {levelCode, 1'b0});
    end else begin
      attenHalfDb = 5'h00;
    end
  end

endmodule

// >>> rtl/aba_agc_dec.sv
// Left gain-control decoder: target, attack and decay codes to values.
// Assumes the codes come straight from the gain-control register.
`timescale 1ns/1ps
module aba_agc_dec
  import aba_pkg::*;
(
  input wire logic [2:0] targetCode,
  input wire logic [1:0] attackCode,
  input wire logic [1:0] decayCode,
  output logic [5:0] targetHalfDb,
  output logic [4:0] attackMs,
  output logic [8:0] decayMs
);

  // Target: highest level at code zero, lowest at code seven
  always_comb begin
    unique case (targetCode)
      3'h0: targetHalfDb = TGT_HALF_DB_0;
      3'h1: targetHalfDb = TGT_HALF_DB_1;
      3'h2: targetHalfDb = TGT_HALF_DB_2;
      3'h3: targetHalfDb = TGT_HALF_DB_3;
      3'h4: targetHalfDb = TGT_HALF_DB_4;
      3'h5: targetHalfDb = TGT_HALF_DB_5;
      3'h6: targetHalfDb = TGT_HALF_DB_6;
      3'h7: targetHalfDb = TGT_HALF_DB_7;
    endcase
  end

  // Attack time select
  always_comb begin
    unique case (attackCode)
      2'h0: attackMs = ATK_MS_0;
      2'h1: attackMs = ATK_MS_1;
      2'h2: attackMs = ATK_MS_2;
      2'h3: attackMs = ATK_MS_3;
    endcase
  end

  // Decay time select
  always_comb begin
    unique case (decayCode)
      2'h0: decayMs = DCY_MS_0;
      2'h1: decayMs = DCY_MS_1;
      2'h2: decayMs = DCY_MS_2;
      2'h3: decayMs = DCY_MS_3;
    endcase
  end

endmodule

// >>> rtl/aba_regs.sv
// Page-zero control registers for line-input routing to the right ADC
// mixer, microphone bias with digital microphone assignment, and the
// left automatic gain control.
// Assumes a byte-wide register port from the control-port decoder on
// the same clock, so no synchronisers are placed on it.
// Reserved bits are masked on write, so they always read back zero.
// Reserved gain and microphone codes are kept but decode as off.
// Decoded outputs change at the edge that takes the write, so the
// host sees them one cycle after its strobe.
`timescale 1ns/1ps
module aba_regs
  import aba_pkg::*;
(
  // Block clock; every register below runs on it
  input wire logic clk,
  // Asynchronous reset, active low
  input wire logic rst_n,
  // Register port, driven from logic on this clock
  // Write strobe, one cycle per byte
  input wire logic regWrite,
  // Read strobe, one cycle per byte
  input wire logic regRead,
  // Register offset on page zero
  input wire logic [6:0] regAddr,
  // Byte to be written
  input wire logic [7:0] regWdata,
  // Read answer, held until the next read
  output logic [7:0] regRdata,
  // Read answer strobe, one cycle after the read
  output logic regRvalid,
  // Controls from other registers of the device
  // High while digital microphone input is enabled
  input wire logic digitalMicEnable,
  // High while double-rate audio is on
  input wire logic doubleRateAudio,
  // Line input to right ADC mixer
  // High for differential, low for single-ended
  output logic lineInDifferential,
  // High while a valid gain code is held
  output logic lineInConnected,
  // Attenuation in half-dB steps, zero when open
  output logic [4:0] lineInAttenHalfDb,
  // Microphone bias output select, one-hot
  output logic biasPoweredDown,
  output logic bias2v0,
  output logic bias2v5,
  output logic biasToSupply,
  // Digital microphone assignment
  // Left channel taken from its digital microphone
  output logic leftUsesDigitalMic,
  // Right channel taken from its digital microphone
  output logic rightUsesDigitalMic,
  // Left automatic gain control
  // Gain control on
  output logic agcEnable,
  // Target level in half-dB below full scale
  output logic [5:0] agcTargetHalfDb,
  // Attack time in milliseconds
  output logic [4:0] agcAttackMs,
  // Decay time in milliseconds
  output logic [8:0] agcDecayMs,
  // Low while double-rate audio skews the time constants
  output logic agcTimingNominal
);

  // Whole state of the block, registered as one word
  // Outputs live here too, so each one leaves a flip-flop
  typedef struct packed {
    // Register images
    logic [7:0] route;      // Routing register image
    logic [7:0] bias;       // Bias register image
    logic [7:0] agc;        // Gain-control register image
    // Read answer
    logic [7:0] rdata;      // Read answer
    logic rvalid;           // Read answer strobe
    // Line input outputs
    logic diff;             // Input mode out
    logic conn;             // Input connected out
    logic [4:0] atten;      // Attenuation out
    // Bias select outputs
    logic bOff;             // Bias off
    logic b20;              // Bias 2.0V
    logic b25;              // Bias 2.5V
    logic bSup;             // Bias tied to supply
    // Microphone outputs
    logic dmL;              // Left digital microphone used
    logic dmR;              // Right digital microphone used
    // Gain control outputs
    logic agcEn;            // Gain control enabled
    logic [5:0] tgt;        // Target level
    logic [4:0] atk;        // Attack time
    logic [8:0] dcy;        // Decay time
    logic nominal;          // Timings at nominal rate
  } aba_state_t;

  aba_state_t s;       // Current state
  aba_state_t next_s;  // Next state

  // Decoder results from the next register images
  logic decConn;
  logic [4:0] decAtten;
  logic [5:0] decTgt;
  logic [4:0] decAtk;
  logic [8:0] decDcy;

  // Next images of the two decoded registers, formed apart from the
  // state process: feeding the decoders from next_s would loop their
  // results back into the process that drives their inputs
  logic [7:0] next_route; // Routing image after this cycle's write
  logic [7:0] next_agc; // Gain-control image after this cycle's write

  // Same masked write as the state process
  assign next_route = (regWrite && regAddr == ROUTE_ADDR) ?
    (regWdata & ROUTE_WR_MASK) : s.route;
  assign next_agc = (regWrite && regAddr == AGC_ADDR) ?
    (regWdata & AGC_WR_MASK) : s.agc;

  // Level decoder for the routing register
  // Codes above eight leave the input open and unattenuated
  aba_level_dec levelDec (
    .levelCode(next_route[ROUTE_LVL_HI:ROUTE_LVL_LO]),
    .connected(decConn),
    .attenHalfDb(decAtten)
  );

  // Target and time decoder for the gain-control register
  // Every code of these fields is legal, so none needs a fallback
  aba_agc_dec agcDec (
    .targetCode(next_agc[AGC_TGT_HI:AGC_TGT_LO]),
    .attackCode(next_agc[AGC_ATK_HI:AGC_ATK_LO]),
    .decayCode(next_agc[AGC_DCY_HI:AGC_DCY_LO]),
    .targetHalfDb(decTgt),
    .attackMs(decAtk),
    .decayMs(decDcy)
  );

  // Next-state logic: register writes, reads and decoded outputs
  // A read and a write in one cycle are both served: the read answers
  // with the image held before the edge, the write lands at the edge.
  always_comb begin
    // Hold everything by default; the read strobe lasts one cycle
    next_s = s;
    next_s.rvalid = 1'b0;

    // Writes; reserved bits are masked so they always read zero
    // Reserved gain and microphone codes are kept as written
    if (regWrite) begin
      unique case (regAddr)
        ROUTE_ADDR: begin
          next_s.route = regWdata & ROUTE_WR_MASK;
        end
        BIAS_ADDR: begin
          next_s.bias = regWdata & BIAS_WR_MASK;
        end
        AGC_ADDR: begin
          next_s.agc = regWdata & AGC_WR_MASK;
        end
        default: begin
          // Unmapped write is ignored
        end
      endcase
    end

    // Reads return the value held before any same-cycle write
    // An unmapped offset still answers, with zero
    if (regRead) begin
      next_s.rvalid = 1'b1;
      unique case (regAddr)
        ROUTE_ADDR: begin
          next_s.rdata = s.route;
        end
        BIAS_ADDR: begin
          // Low bits were masked on write, so they read zero
          next_s.rdata = s.bias;
        end
        AGC_ADDR: begin
          next_s.rdata = s.agc;
        end
        default: begin
          next_s.rdata = UNMAPPED_READ;
        end
      endcase
    end

    // Input mode and level follow the routing register
    // Decoded from the new image, so they move with the write edge
    next_s.diff = next_s.route[ROUTE_DIFF_BIT];
    next_s.conn = decConn;
    next_s.atten = decAtten;

    // Bias select is one-hot over the four levels
    // Only bits 7:6 matter; the microphone field is decoded below
    next_s.bOff = (next_s.bias[BIAS_LVL_HI:BIAS_LVL_LO] == BIAS_OFF);
    next_s.b20 = (next_s.bias[BIAS_LVL_HI:BIAS_LVL_LO] == BIAS_2V0);
    next_s.b25 = (next_s.bias[BIAS_LVL_HI:BIAS_LVL_LO] == BIAS_2V5);
    next_s.bSup = (next_s.bias[BIAS_LVL_HI:BIAS_LVL_LO] == BIAS_SUPPLY);

    // Digital microphone assignment, only when enabled
    // With digital input off both channels keep their own ADCs
    next_s.dmL = 1'b0;
    next_s.dmR = 1'b0;
    if (digitalMicEnable) begin
      unique case (next_s.bias[BIAS_DMIC_HI:BIAS_DMIC_LO])
        DMIC_BOTH: begin
          next_s.dmL = 1'b1;
          next_s.dmR = 1'b1;
        end
        DMIC_LEFT: begin
          next_s.dmL = 1'b1;
        end
        DMIC_RIGHT: begin
          next_s.dmR = 1'b1;
        end
        DMIC_RSVD: begin
          // Reserved code falls back to both ADCs
        end
      endcase
    end

    // Left gain control settings
    // Target, attack and decay come from the new image as well
    next_s.agcEn = next_s.agc[AGC_EN_BIT];
    next_s.tgt = decTgt;
    next_s.atk = decAtk;
    next_s.dcy = decDcy;
    // Time constants are nominal only without double-rate audio
    // Registered like every output, so it trails its input by a cycle
    next_s.nominal = ~doubleRateAudio;
  end

  // State register with reset images
  // The reset branch loads constants only, so no reset value can
  // depend on another flip-flop coming out of reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Clear everything, then set the non-zero reset images
      s <= '0;
      // Register images
      s.route <= ROUTE_RESET;
      s.bias <= BIAS_RESET;
      s.agc <= AGC_RESET;
      // Read answer empty
      s.rdata <= UNMAPPED_READ;
      // Decoded outputs agree with the images above while digital microphone input and double-rate audio are off
      s.bOff <= 1'b1;
      s.tgt <= TGT_HALF_DB_0;
      s.atk <= ATK_MS_0;
      s.dcy <= DCY_MS_0;
      s.nominal <= 1'b1;
    end else begin
      // One word moves at each edge
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  // No logic stands between a flip-flop and a pin
  // Register port answer
  assign regRdata = s.rdata;
  assign regRvalid = s.rvalid;

  // Line input to the right ADC mixer
  assign lineInDifferential = s.diff;
  assign lineInConnected = s.conn;
  assign lineInAttenHalfDb = s.atten;

  // Bias select
  assign biasPoweredDown = s.bOff;
  assign bias2v0 = s.b20;
  assign bias2v5 = s.b25;
  assign biasToSupply = s.bSup;

  // Digital microphone assignment
  assign leftUsesDigitalMic = s.dmL;
  assign rightUsesDigitalMic = s.dmR;

  // Left gain control
  assign agcEnable = s.agcEn;
  assign agcTargetHalfDb = s.tgt;
  assign agcAttackMs = s.atk;
  assign agcDecayMs = s.dcy;
  assign agcTimingNominal = s.nominal;

endmodule

// >>> dv/aba_regs_assertions.sv
// Checker for the page-zero control register block.
// Assumes it is bound into aba_regs on one clock.
`timescale 1ns/1ps
module aba_regs_assertions
  import aba_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic doubleRateAudio,
  input wire logic lineInDifferential,
  input wire logic lineInConnected,
  input wire logic [4:0] lineInAttenHalfDb,
  input wire logic biasPoweredDown,
  input wire logic bias2v0,
  input wire logic bias2v5,
  input wire logic biasToSupply,
  input wire logic agcEnable,
  input wire logic agcTimingNominal
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Accepted writes, one per register
  sequence s_route_wr;
    regWrite && regAddr == ROUTE_ADDR;
  endsequence
  sequence s_bias_wr;
    regWrite && regAddr == BIAS_ADDR;
  endsequence
  sequence s_agc_wr;
    regWrite && regAddr == AGC_ADDR;
  endsequence
  a_route_diff: assert property (
    s_route_wr |=> lineInDifferential == $past(regWdata[7]))
    else $error("input mode does not follow write");
  a_level_gain: assert property (
    s_route_wr ##0 regWdata[6:3] <= LVL_MAX_CODE |=> lineInConnected &&
    lineInAttenHalfDb == 5'($past(regWdata[6:3]) * 3))
    else $error("level code gain wrong");
  a_level_open: assert property (
    s_route_wr ##0 regWdata[6:3] > LVL_MAX_CODE |=>
    !lineInConnected && lineInAttenHalfDb == 5'h00)
    else $error("open level code still connected");
  a_resv_read: assert property (
    regRead && regAddr != AGC_ADDR |=> regRdata[2:0] == 3'h0)
    else $error("reserved low bits read nonzero");
  a_bias_select: assert property (
    s_bias_wr |=> {biasPoweredDown, bias2v0, bias2v5, biasToSupply} ==
    4'h8 >> $past(regWdata[7:6]))
    else $error("bias select wrong");
  a_bias_resv: assert property (
    regRead && regAddr == BIAS_ADDR |=> regRdata[3:0] == 4'h0)
    else $error("bias reserved bits read nonzero");
  a_agc_enable: assert property (
    s_agc_wr |=> agcEnable == $past(regWdata[7]))
    else $error("gain control enable wrong");
  a_timing_nominal: assert property (
    agcTimingNominal == !$past(doubleRateAudio))
    else $error("timing flag does not track double rate");
endmodule

bind aba_regs aba_regs_assertions aba_regs_assertions_i (.clk, .rst_n,
  .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .doubleRateAudio,
  .lineInDifferential, .lineInConnected, .lineInAttenHalfDb,
  .biasPoweredDown, .bias2v0, .bias2v5, .biasToSupply, .agcEnable,
  .agcTimingNominal);

// >>> dv/aba_regs_tb.sv
// Self-checking bench for the page-zero control register block.
// Assumes aba_regs as top, with its checker bound in.
`timescale 1ns/1ps
module testbench import aba_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [6:0] regAddr = 7'h00;
  logic [7:0] regWdata = 8'h00;
  logic digitalMicEnable = 1'b0;
  logic doubleRateAudio = 1'b0;
  logic [7:0] regRdata, route, bias, agc, d;
  logic regRvalid, lineInDifferential, lineInConnected, agcEnable;
  logic biasPoweredDown, bias2v0, bias2v5, biasToSupply;
  logic leftUsesDigitalMic, rightUsesDigitalMic, agcTimingNominal;
  logic [4:0] lineInAttenHalfDb, agcAttackMs;
  logic [5:0] agcTargetHalfDb;
  logic [8:0] agcDecayMs;
  logic [6:0] a;
  logic [42:0] expQ[$];
  int bad_count = 0;
  int n_compared = 0;
  integer seed = 32'h1550;
  int i;
  // Decoded value tables
  logic [5:0] tgtTab [8] = '{6'h0b, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h22,
    6'h28, 6'h30};
  logic [4:0] atkTab [4] = '{5'h08, 5'h0b, 5'h10, 5'h14};
  logic [8:0] dcyTab [4] = '{9'h064, 9'h0c8, 9'h190, 9'h1f4};
  // Everything one read answer shows
  wire logic [42:0] obs = {regRdata, lineInDifferential, lineInConnected,
    lineInAttenHalfDb, biasPoweredDown, bias2v0, bias2v5, biasToSupply,
    leftUsesDigitalMic, rightUsesDigitalMic, agcEnable, agcTargetHalfDb,
    agcAttackMs, agcDecayMs, agcTimingNominal};

  always #2.5 clk = ~clk;

  aba_regs aba_regs_i (.clk, .rst_n, .regWrite, .regRead, .regAddr,
    .regWdata, .regRdata, .regRvalid, .digitalMicEnable, .doubleRateAudio,
    .lineInDifferential, .lineInConnected, .lineInAttenHalfDb,
    .biasPoweredDown, .bias2v0, .bias2v5, .biasToSupply,
    .leftUsesDigitalMic, .rightUsesDigitalMic, .agcEnable,
    .agcTargetHalfDb, .agcAttackMs, .agcDecayMs, .agcTimingNominal);

  // Expected decoded outputs from the shadow registers
  function automatic logic [34:0] dec();
    logic [3:0] lvl;
    logic [1:0] dm;
    lvl = route[6:3];
    dm = 2'h0;
    if (digitalMicEnable && bias[5:4] != 2'h3) begin
      dm = (bias[5:4] == 2'h0) ? 2'h3 : ~bias[5:4];
    end
    return {route[7], lvl <= 4'h8, (lvl <= 4'h8) ? 5'(lvl * 3) : 5'h00,
      4'h8 >> bias[7:6], dm, agc[7], tgtTab[agc[6:4]], atkTab[agc[3:2]],
      dcyTab[agc[1:0]], !doubleRateAudio};
  endfunction

  // One port cycle; a read notes its answer, old data first
  task automatic acc(logic w, logic r, logic [6:0] ad, logic [7:0] wd);
    logic [7:0] old;
    @(posedge clk);
    regWrite <= w;
    regRead <= r;
    regAddr <= ad;
    regWdata <= wd;
    old = (ad == ROUTE_ADDR) ? route : (ad == BIAS_ADDR) ? bias :
      (ad == AGC_ADDR) ? agc : 8'h00;
    if (w && ad == ROUTE_ADDR) route = wd & 8'hf8;
    if (w && ad == BIAS_ADDR) bias = wd & 8'hf0;
    if (w && ad == AGC_ADDR) agc = wd;
    if (r) expQ.push_back({old, dec()});
    @(posedge clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
  endtask

  // Reset pulse with shadow reload
  task automatic rstAll();
    @(posedge clk);
    rst_n <= 1'b0;
    route = 8'h78;
    bias = 8'h00;
    agc = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic chk(logic [42:0] e, logic [42:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("compared=%0d mismatched=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Oldest note against each read answer
  always @(posedge clk) begin
    if (rst_n && regRvalid === 1'b1) begin
      chk(expQ.size() ? expQ.pop_front() : {43{1'bx}}, obs);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    rstAll();
    for (i = 0; i < 4; i++) acc(0, 1, 7'h18 + 7'(i), 8'h00);
    $display("reset values done");
    for (i = 0; i < 10; i++) begin
      d = {i[0], (i == 9) ? 4'hf : 4'(i), 3'h0};
      acc(1, 0, ROUTE_ADDR, d);
      acc(0, 1, ROUTE_ADDR, d);
    end
    $display("level codes done");
    for (i = 0; i < 24; i++) begin
      digitalMicEnable <= i[0];
      acc(1, 0, BIAS_ADDR, {i[2:1], 2'(i / 8), 4'h0});
      acc(0, 1, BIAS_ADDR, 8'h00);
    end
    $display("bias and microphones done");
    for (i = 0; i < 16; i++) begin
      doubleRateAudio <= i[0];
      acc(1, 0, AGC_ADDR, {i[3], i[2:0], i[1:0], i[3:2]});
      acc(0, 1, AGC_ADDR, 8'h00);
    end
    doubleRateAudio <= 1'b0;
    acc(1, 1, AGC_ADDR, 8'h5a);
    acc(1, 1, AGC_ADDR, 8'ha5);
    acc(0, 1, AGC_ADDR, 8'h00);
    $display("gain control done");
    for (i = 0; i < 40; i++) begin
      a = 7'h17 + 7'($unsigned($random(seed)) % 5);
      d = 8'($random(seed));
      if (a == ROUTE_ADDR && d[6:3] > 4'h8) d[6:3] = 4'hf;
      if (a == BIAS_ADDR && d[5:4] == 2'h3) d[5:4] = 2'h0;
      if (a == ROUTE_ADDR) d[2:0] = 3'h0;
      if (a == BIAS_ADDR) d[3:0] = 4'h0;
      acc(1, 0, a, d);
      acc(0, 1, a, 8'h00);
    end
    $display("random access done");
    rstAll();
    for (i = 0; i < 4; i++) acc(0, 1, 7'h18 + 7'(i), 8'h00);
    $display("second reset done");
    repeat (3) @(posedge clk);
    if (expQ.size() != 0) bad_count++;
    wrap_up();
  end
endmodule
